// File: logic/plq_pkg.sv
// Package for link quality, strength and ranging capture block
package plq_pkg;
    // Bus geometry
    localparam int          ADR_W          = 8;
    localparam int          DAT_W          = 32;
    localparam int          SEL_W          = 4;

    // Register byte offsets
    localparam logic [7:0]  OFF_CTRL       = 8'h00;
    localparam logic [7:0]  OFF_LQ_STATUS  = 8'h04;
    localparam logic [7:0]  OFF_RANGE_TIME = 8'h08;
    localparam logic [7:0]  OFF_CAL_DELAY  = 8'h0C;
    localparam logic [7:0]  OFF_CEILING    = 8'h10;
    localparam logic [7:0]  OFF_BUSY_THR   = 8'h14;
    localparam logic [7:0]  OFF_CAP_STAT   = 8'h18;
    localparam logic [7:0]  OFF_PKT_COUNT  = 8'h1C;

    // Control field positions
    localparam int          CTRL_LQ_EN     = 0;
    localparam int          CTRL_VENDOR    = 1;
    localparam int          CTRL_RANGE_EN  = 2;
    localparam int          CTRL_W         = 3;

    // Status field positions
    localparam int          ST_CODE_LSB    = 0;
    localparam int          ST_STR_LSB     = 8;
    localparam int          ST_BUSY        = 16;
    localparam int          CAP_FLAG       = 0;
    localparam int          CAP_DIR_RX     = 1;
    localparam int          CAL_RX_LSB     = 16;

    // Reset values
    localparam logic [2:0]  CTRL_RST       = 3'h5;
    localparam logic [7:0]  CEILING_RST    = 8'hFF;
    localparam logic [15:0] BUSY_THR_RST   = 16'h8000;

    // Quality code encoding
    localparam int          EST_W          = 10;
    localparam int          EST_FRAC       = 2;
    localparam int          Q_W            = 9;
    localparam logic signed [8:0] SNR_DB_MIN = -9'sh6;
    localparam logic signed [8:0] SNR_DB_MAX = 9'sh18;
    localparam logic signed [8:0] CODE_OFS   = 9'sh7;
    localparam logic [7:0]  CODE_NONE      = 8'h00;
    localparam logic [7:0]  CODE_VENDOR    = 8'h80;

    // Strength scaling
    localparam int          ENERGY_W       = 16;
    localparam int          STR_SHIFT      = 8;

    // Ranging counter and timestamp layout
    localparam int          RCNT_W         = 15;
    localparam int          TS_LSB         = 3;
    localparam int          TS_W           = 32;
    localparam int          SYS_CLK_MHZ    = 200;
    localparam int          RANGE_CLK_MHZ  = 528;
    localparam int          TICK_WHOLE     = RANGE_CLK_MHZ / SYS_CLK_MHZ;
    localparam int          TICK_REM       = RANGE_CLK_MHZ % SYS_CLK_MHZ;
    localparam int          FRAC_W         = 8;
    localparam int          CAL_W          = 16;
endpackage

// File: logic/plq_link_quality.sv
// Link quality code, strength, busy detect and ranging timestamp capture
//
// The address map and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module plq_link_quality #(
    parameter logic [15:0] TX_PATH_DELAY = 16'h0000,
    parameter logic [15:0] RX_PATH_DELAY = 16'h0000
) (
    input  wire logic                             i_clk,
    input  wire logic                             i_rstn,
    // Wishbone classic slave
    input  wire logic                             i_wb_cyc,
    input  wire logic                             i_wb_stb,
    input  wire logic                             i_wb_we,
    input  wire logic [plq_pkg::ADR_W-1:0]        i_wb_adr,
    input  wire logic [plq_pkg::SEL_W-1:0]        i_wb_sel,
    input  wire logic [plq_pkg::DAT_W-1:0]        i_wb_dat,
    output logic      [plq_pkg::DAT_W-1:0]        o_wb_dat,
    output logic                                  o_wb_ack,
    // Per-packet SNR estimate from the receiver
    input  wire logic                             i_snr_valid,
    input  wire logic signed [plq_pkg::EST_W-1:0] i_snr_estimate_db,
    input  wire logic                             i_snr_measurable,
    input  wire logic [6:0]                       i_vendor_quality,
    output logic      [7:0]                       o_quality_report_code,
    output logic                                  o_quality_valid,
    // Energy and busy detection
    input  wire logic                             i_energy_valid,
    input  wire logic [plq_pkg::ENERGY_W-1:0]     i_energy,
    input  wire logic                             i_preamble_detect,
    input  wire logic                             i_rx_active,
    output logic      [7:0]                       o_received_strength_value,
    output logic                                  o_channel_busy_detect,
    // Ranging reference point strobes
    input  wire logic                             i_tx_active,
    input  wire logic                             i_tx_ref_point,
    input  wire logic                             i_rx_ref_point,
    output logic      [plq_pkg::TS_W-1:0]         o_ranging_timestamp,
    output logic                                  o_ranging_captured,
    output logic      [plq_pkg::CAL_W-1:0]        o_ranging_tx_delay,
    output logic      [plq_pkg::CAL_W-1:0]        o_ranging_rx_delay
);
    import plq_pkg::*;

    // Register map, byte addresses, 32-bit words:
    //   00h control, read-write
    //       bit 0  quality reporting enable
    //       bit 1  vendor code mode
    //       bit 2  ranging capture enable
    //   04h link status, read-only
    //       bits 7:0   last quality code
    //       bits 15:8  last strength value
    //       bit 16     channel busy
    //   08h ranging timestamp, read-only
    //       bits 17:3  captured count, rest zero
    //   0Ch path-delay constants, read-only
    //       bits 15:0  transmit delay
    //       bits 31:16 receive delay
    //   10h strength ceiling, read-write, bits 7:0
    //   14h busy energy threshold, read-write
    //   18h capture status
    //       bit 0  capture seen, write one to clear
    //       bit 1  last capture came from receive
    //   1Ch packet count, read-only, bits 15:0
    //
    // Unmapped addresses acknowledge with zero data.
    // Writes to read-only words are dropped quietly.
    //
    // Bus timing:
    //   Request taken on the edge it is seen.
    //   Ack stands for exactly one clock.
    //   Ack gates the request, so a strobe still
    //   high in the ack cycle cannot start a second
    //   access by accident.
    //
    // Quality path:
    //   Estimate arrives in quarter dB, signed.
    //   Code and valid pulse follow one clock later.
    //   Ties round upward, toward plus infinity.
    //   Code stands until the next packet.
    //
    // Strength path:
    //   Energy shifted down, then clipped at the
    //   ceiling; both steps keep the ordering.
    //   A ceiling of zero pins the value at zero.
    //
    // Ranging counter:
    //   The fast count is emulated on this clock
    //   by a fractional accumulator, so each edge
    //   advances it by two or three counts.
    //   Limitation: the stamp resolution is one
    //   system clock, not one fast count; the
    //   long-run rate is exact.
    //   Transmit wins when both strobes coincide while transmitting.
    //
    // Path-delay constants come from parameters
    // and are fixed per build; calibrate per board.

    typedef struct packed {
        logic [CTRL_W-1:0]   ctrl;
        logic [7:0]          ceiling;
        logic [ENERGY_W-1:0] busy_thr;
        logic [7:0]          quality;
        logic                quality_valid;
        logic [7:0]          strength;
        logic                busy;
        logic [15:0]         pkt_count;
        logic [RCNT_W-1:0]   rcount;
        logic [FRAC_W-1:0]   frac;
        logic [RCNT_W-1:0]   ts_count;
        logic                cap_pulse;
        logic                cap_flag;
        logic                cap_dir_rx;
        logic                ack;
        logic [DAT_W-1:0]    rdata;
    } plq_state_s;

    plq_state_s state;
    plq_state_s next_state;

    logic [1:0] rst_sync;
    logic       rst_n;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    function automatic logic reg_hit(input logic [ADR_W-1:0] adr,
                                     input logic [7:0]       off);
        reg_hit = (adr[ADR_W-1:2] == off[7:2]);
    endfunction

    function automatic logic [DAT_W-1:0] apply_sel(
        input logic [DAT_W-1:0] old_val,
        input logic [DAT_W-1:0] new_val,
        input logic [SEL_W-1:0] sel);
        logic [DAT_W-1:0] res;
        res = old_val;
        for (int b = 0; b < SEL_W; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        apply_sel = res;
    endfunction

    // Quarter-dB estimate to clamped standard code
    function automatic logic [7:0] encode_snr(
        input logic signed [EST_W-1:0] est);
        logic signed [EST_W:0] rounded;
        logic signed [Q_W-1:0] q;
        logic signed [Q_W-1:0] sum;
        // Half an LSB added before the arithmetic shift: nearest dB
        rounded = ($signed({est[EST_W-1], est}) + 11'sh2) >>> EST_FRAC;
        // Input span keeps the shifted value inside nine bits
        q = rounded[Q_W-1:0];

        // Clamp keeps mapping monotonic and out of the reserved span
        // Saturating, not wrapping: a strong link never reads as weak
        if (q < SNR_DB_MIN) begin
            q = SNR_DB_MIN;
        end else if (q > SNR_DB_MAX) begin
            q = SNR_DB_MAX;
        end

        // Offset moves the lowest whole dB onto code 01h
        sum = q + CODE_OFS;
        encode_snr = sum[7:0];
    endfunction

    logic                 wb_req;
    logic                 wb_wr;
    logic [DAT_W-1:0]     ctrl_word;
    logic [DAT_W-1:0]     ceil_word;
    logic [DAT_W-1:0]     thr_word;
    logic [DAT_W-1:0]     rd_word;
    logic [TS_W-1:0]      ts_word;
    logic [FRAC_W:0]      frac_sum;
    logic [RCNT_W-1:0]    tick_adv;
    logic [ENERGY_W-1:0]  str_scaled;
    logic [7:0]           str_clip;
    logic [7:0]           ceil_eff;
    logic                 tx_cap;
    logic                 rx_cap;

    // Unused counter bits are tied to zero here
    always_comb begin
        ts_word = '0;
        ts_word[TS_LSB +: RCNT_W] = state.ts_count;
    end

    always_comb begin
        next_state = state;
        next_state.quality_valid = 1'b0;
        next_state.cap_pulse = 1'b0;
        wb_req = i_wb_cyc && i_wb_stb && !state.ack;
        wb_wr = wb_req && i_wb_we;
        ctrl_word = '0;
        ceil_word = '0;
        thr_word = '0;
        rd_word = '0;


        // Free-running count, 2.64 ticks of 528 MHz per 5 ns clock
        // Remainder accumulates so no count is ever lost
        frac_sum = {1'b0, state.frac} + (FRAC_W+1)'(TICK_REM);
        tick_adv = RCNT_W'(TICK_WHOLE);
        if (frac_sum >= (FRAC_W+1)'(SYS_CLK_MHZ)) begin
            frac_sum = frac_sum - (FRAC_W+1)'(SYS_CLK_MHZ);
            tick_adv = RCNT_W'(TICK_WHOLE + 1);
        end
        next_state.frac = frac_sum[FRAC_W-1:0];
        next_state.rcount = state.rcount + tick_adv;


        // Reference strobe marks first sample of first CE symbol
        // Receive capture is masked while transmitting
        tx_cap = state.ctrl[CTRL_RANGE_EN] && i_tx_active
                 && i_tx_ref_point;
        rx_cap = state.ctrl[CTRL_RANGE_EN] && i_rx_active
                 && !i_tx_active && i_rx_ref_point;
        if (tx_cap || rx_cap) begin
            next_state.ts_count = state.rcount;
            next_state.cap_dir_rx = rx_cap;
            next_state.cap_pulse = 1'b1;
        end


        // Each packet replaces the code outright; no history kept
        if (i_snr_valid) begin
            next_state.quality_valid = 1'b1;
            next_state.pkt_count = state.pkt_count + 16'h0001;
            if (!state.ctrl[CTRL_LQ_EN] || !i_snr_measurable) begin
                next_state.quality = CODE_NONE;
            end else if (state.ctrl[CTRL_VENDOR]) begin
                next_state.quality = CODE_VENDOR | {1'b0, i_vendor_quality};
            end else begin
                // Wide input covers -6..+24 dB and beyond
                next_state.quality = encode_snr(i_snr_estimate_db);
            end
        end


        // Coarse scale then clip; both steps preserve ordering
        str_scaled = i_energy >> STR_SHIFT;
        str_clip = str_scaled[7:0];
        ceil_eff = state.ceiling;
        if (str_clip > ceil_eff) begin
            str_clip = ceil_eff;
        end
        if (i_energy_valid) begin
            next_state.strength = str_clip;
        end


        // One clock of latency, far inside any detect window
        next_state.busy = i_preamble_detect || i_rx_active
                          || (i_energy >= state.busy_thr);


        // Register reads
        // Decoded every cycle; only captured while a read is taken
        if (reg_hit(i_wb_adr, OFF_CTRL)) begin
            rd_word[CTRL_W-1:0] = state.ctrl;
        end else if (reg_hit(i_wb_adr, OFF_LQ_STATUS)) begin
            rd_word[ST_CODE_LSB +: 8] = state.quality;
            rd_word[ST_STR_LSB +: 8] = state.strength;
            rd_word[ST_BUSY] = state.busy;
        end else if (reg_hit(i_wb_adr, OFF_RANGE_TIME)) begin
            rd_word = ts_word;
        end else if (reg_hit(i_wb_adr, OFF_CAL_DELAY)) begin
            rd_word[CAL_W-1:0] = TX_PATH_DELAY;
            rd_word[CAL_RX_LSB +: CAL_W] = RX_PATH_DELAY;
        end else if (reg_hit(i_wb_adr, OFF_CEILING)) begin
            rd_word[7:0] = state.ceiling;
        end else if (reg_hit(i_wb_adr, OFF_BUSY_THR)) begin
            rd_word[ENERGY_W-1:0] = state.busy_thr;
        end else if (reg_hit(i_wb_adr, OFF_CAP_STAT)) begin
            rd_word[CAP_FLAG] = state.cap_flag;
            rd_word[CAP_DIR_RX] = state.cap_dir_rx;
        end else if (reg_hit(i_wb_adr, OFF_PKT_COUNT)) begin
            rd_word[15:0] = state.pkt_count;
        end


        // Register writes; read-only and unmapped addresses ignore data
        if (wb_wr && reg_hit(i_wb_adr, OFF_CTRL)) begin
            ctrl_word = apply_sel(DAT_W'(state.ctrl), i_wb_dat, i_wb_sel);
            next_state.ctrl = ctrl_word[CTRL_W-1:0];
        end
        if (wb_wr && reg_hit(i_wb_adr, OFF_CEILING)) begin
            ceil_word = apply_sel(DAT_W'(state.ceiling), i_wb_dat, i_wb_sel);
            next_state.ceiling = ceil_word[7:0];
        end
        if (wb_wr && reg_hit(i_wb_adr, OFF_BUSY_THR)) begin
            thr_word = apply_sel(DAT_W'(state.busy_thr), i_wb_dat, i_wb_sel);
            next_state.busy_thr = thr_word[ENERGY_W-1:0];
        end
        if (wb_wr && reg_hit(i_wb_adr, OFF_CAP_STAT) && i_wb_sel[0]
            && i_wb_dat[CAP_FLAG]) begin
            next_state.cap_flag = 1'b0;
        end
        // A capture in the clearing cycle still leaves the flag set
        if (tx_cap || rx_cap) begin
            next_state.cap_flag = 1'b1;
        end


        // Ack one clock after the taken edge, for one clock only
        next_state.ack = wb_req;
        if (wb_req && !i_wb_we) begin
            next_state.rdata = rd_word;
        end
    end

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
            state.ctrl <= CTRL_RST;
            state.ceiling <= CEILING_RST;
            state.busy_thr <= BUSY_THR_RST;
        end else begin
            state <= next_state;
        end
    end

    assign o_wb_ack = state.ack;
    assign o_wb_dat = state.rdata;
    assign o_quality_report_code = state.quality;
    assign o_quality_valid = state.quality_valid;
    assign o_received_strength_value = state.strength;
    assign o_channel_busy_detect = state.busy;
    assign o_ranging_timestamp = ts_word;
    assign o_ranging_captured = state.cap_pulse;
    // Constants measured per board; MAC applies them to timestamps
    assign o_ranging_tx_delay = TX_PATH_DELAY;
    assign o_ranging_rx_delay = RX_PATH_DELAY;

endmodule
`default_nettype wire

// File: sim/plq_mac_model.sv
// Far-side model: MAC applying path-delay calibration to timestamps
`timescale 1ns/1ps
`default_nettype none
module plq_mac_model (
    input  wire logic        i_clk,
    input  wire logic        i_captured,
    input  wire logic        i_from_rx,
    input  wire logic [31:0] i_ts,
    input  wire logic [15:0] i_tx_delay,
    input  wire logic [15:0] i_rx_delay,
    output logic      [31:0] o_cal_time
);
    // Takes the stamp in the cycle the capture pulse stands
    always_ff @(posedge i_clk) begin
        if (i_captured) begin
            o_cal_time <= i_from_rx ? i_ts - {16'h0, i_rx_delay}
                                    : i_ts + {16'h0, i_tx_delay};
        end
    end
endmodule
`default_nettype wire

// File: sim/plq_link_quality_properties.sv
// Assertion checker for the link quality and ranging block
`timescale 1ns/1ps
`default_nettype none
module plq_props (
    input wire logic               i_clk,
    input wire logic               i_rstn,
    input wire logic               i_snr_valid,
    input wire logic signed [9:0]  i_snr_estimate_db,
    input wire logic               i_snr_measurable,
    input wire logic [7:0]         o_quality_report_code,
    input wire logic               o_quality_valid,
    input wire logic               i_preamble_detect,
    input wire logic               o_channel_busy_detect,
    input wire logic               i_tx_active,
    input wire logic               i_tx_ref_point,
    input wire logic               i_rx_active,
    input wire logic               i_rx_ref_point,
    input wire logic [31:0]        o_ranging_timestamp,
    input wire logic               o_ranging_captured
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    // Widened by one bit so the rounding offset cannot overflow
    function automatic logic [7:0] ecode(logic signed [9:0] e);
        logic signed [10:0] q;
        q = ($signed({e[9], e}) + 11'sh2) >>> 2;
        if (q < -11'sh6) q = -11'sh6;
        if (q > 11'sh18) q = 11'sh18;
        return 8'(q + 11'sh7);
    endfunction
    property p_no_resv; o_quality_valid |->
        !(o_quality_report_code inside {[8'h20:8'h7F]}); endproperty
    a_no_resv: assert property (p_no_resv) else $error("reserved code");
    property p_fresh; i_snr_valid |=> o_quality_valid; endproperty
    a_fresh: assert property (p_fresh) else $error("no code");
    property p_only; o_quality_valid |-> $past(i_snr_valid); endproperty
    a_only: assert property (p_only) else $error("stray code");
    property p_enc; o_quality_valid && o_quality_report_code inside
        {[8'h01:8'h1F]} |-> o_quality_report_code ==
        ecode($past(i_snr_estimate_db)); endproperty
    a_enc: assert property (p_enc) else $error("bad code");
    property p_unmeas; i_snr_valid && !i_snr_measurable |=>
        o_quality_report_code == 8'h00; endproperty
    a_unmeas: assert property (p_unmeas) else $error("not zero");
    property p_ts_bits; o_ranging_timestamp[31:18] == 14'h0 &&
        o_ranging_timestamp[2:0] == 3'h0; endproperty
    a_ts_bits: assert property (p_ts_bits) else $error("stamp bits");
    property p_ts_hold; !o_ranging_captured |->
        $stable(o_ranging_timestamp); endproperty
    a_ts_hold: assert property (p_ts_hold) else $error("stamp moved");
    property p_cap; o_ranging_captured |-> $past(i_tx_ref_point &&
        i_tx_active || i_rx_ref_point && i_rx_active); endproperty
    a_cap: assert property (p_cap) else $error("stray capture");
    property p_busy; i_preamble_detect |=> o_channel_busy_detect; endproperty
    a_busy: assert property (p_busy) else $error("busy late");
endmodule
bind plq_link_quality plq_props plq_props_i (.i_clk, .i_rstn, .i_snr_valid,
    .i_snr_estimate_db, .i_snr_measurable, .o_quality_report_code,
    .o_quality_valid, .i_preamble_detect, .o_channel_busy_detect,
    .i_tx_active, .i_tx_ref_point, .i_rx_active, .i_rx_ref_point,
    .o_ranging_timestamp, .o_ranging_captured);
`default_nettype wire

// File: sim/testbench.sv
// Self-checking testbench for the link quality and ranging block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import plq_pkg::*;
    localparam logic [15:0] TXD = 16'h0123;
    localparam logic [15:0] RXD = 16'h0045;
    logic i_clk = 1'h0, i_rstn = 1'h0, i_wb_cyc = 1'h0, i_wb_stb = 1'h0;
    logic i_wb_we = 1'h0, o_wb_ack, i_snr_valid = 1'h0, o_quality_valid;
    logic i_snr_measurable = 1'h0, i_energy_valid = 1'h0, o_ranging_captured;
    logic i_preamble_detect = 1'h0, i_rx_active = 1'h0, i_tx_active = 1'h0;
    logic i_tx_ref_point = 1'h0, i_rx_ref_point = 1'h0, o_channel_busy_detect;
    logic [7:0] i_wb_adr = 8'h0, o_quality_report_code, o_received_strength_value;
    logic [3:0] i_wb_sel = 4'hF;
    logic [6:0] i_vendor_quality = 7'h35;
    logic signed [9:0] i_snr_estimate_db = 10'h0;
    logic [15:0] i_energy = 16'h0, o_ranging_tx_delay, o_ranging_rx_delay;
    logic [31:0] i_wb_dat = 32'h0, o_wb_dat, o_ranging_timestamp, ts, cal, r;
    logic [7:0] ra [7] = '{OFF_CTRL, OFF_LQ_STATUS, OFF_CEILING, OFF_BUSY_THR,
        OFF_CAL_DELAY, OFF_RANGE_TIME, 8'h20};
    logic [31:0] rv [7] = '{32'h5, 32'h0, 32'hFF, 32'h8000, {RXD, TXD},
        32'h0, 32'h0};
    int qe [9] = '{-40, -24, -22, 1, 3, 48, 96, 300, 0};
    logic [7:0] qx [9] = '{8'h01, 8'h01, 8'h02, 8'h07, 8'h08, 8'h13, 8'h1F,
        8'h1F, 8'h00};
    int n_fail = 0;
    int samples_checked = 0;
    plq_link_quality #(.TX_PATH_DELAY(TXD), .RX_PATH_DELAY(RXD))
        plq_link_quality_i (.i_clk, .i_rstn, .i_wb_cyc, .i_wb_stb, .i_wb_we,
        .i_wb_adr, .i_wb_sel, .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_snr_valid,
        .i_snr_estimate_db, .i_snr_measurable, .i_vendor_quality,
        .o_quality_report_code, .o_quality_valid, .i_energy_valid, .i_energy,
        .i_preamble_detect, .i_rx_active, .o_received_strength_value,
        .o_channel_busy_detect, .i_tx_active, .i_tx_ref_point, .i_rx_ref_point,
        .o_ranging_timestamp, .o_ranging_captured, .o_ranging_tx_delay,
        .o_ranging_rx_delay);
    plq_mac_model plq_mac_model_i (.i_clk, .i_captured(o_ranging_captured),
        .i_from_rx(i_rx_active & ~i_tx_active), .i_ts(o_ranging_timestamp),
        .i_tx_delay(o_ranging_tx_delay), .i_rx_delay(o_ranging_rx_delay),
        .o_cal_time(cal));
    always #2.5 i_clk = ~i_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge i_clk);
        {i_wb_cyc, i_wb_stb, i_wb_we, i_wb_adr, i_wb_dat} <= {2'h3, w, a, d};
        // Ack is only believed at a rising edge
        do @(posedge i_clk); while (o_wb_ack !== 1'h1 && ++n < 50);
        if (n >= 50) n_fail++;
        q = o_wb_dat;
        {i_wb_cyc, i_wb_stb, i_wb_we} <= 3'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'h0, a, 32'h0, r);
        chk(r, e);
    endtask
    task automatic pkt(input logic [9:0] e, input logic [7:0] x);
        @(posedge i_clk);
        {i_snr_valid, i_snr_estimate_db, i_snr_measurable} <= {1'h1, e, 1'h1};
        @(posedge i_clk);
        i_snr_valid <= 1'h0;
        #1 chk(o_quality_report_code, x);
    endtask
    task automatic en(input logic [15:0] e, input logic p, input logic [7:0] s,
                      input logic b);
        @(posedge i_clk);
        {i_energy_valid, i_energy, i_preamble_detect} <= {1'h1, e, p};
        @(posedge i_clk);
        {i_energy_valid, i_preamble_detect} <= 2'h0;
        #1 chk(o_received_strength_value, s);
        chk(o_channel_busy_detect, b);
    endtask
    task automatic rp(input logic tx, input logic c);
        @(posedge i_clk);
        {i_tx_ref_point, i_rx_ref_point} <= {tx, ~tx};
        @(posedge i_clk);
        {i_tx_ref_point, i_rx_ref_point} <= 2'h0;
        #1 chk(o_ranging_captured, c);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge i_clk);
        i_rstn <= 1'h1;
        repeat (2) @(posedge i_clk);
        wb(1'h1, OFF_CAL_DELAY, 32'hFFFFFFFF, r);
        wb(1'h1, 8'h20, 32'hFFFFFFFF, r);
        for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
        $display("registers done");
        // Packets back to back, last one unmeasurable
        @(posedge i_clk);
        for (int i = 0; i <= 9; i++) begin
            i_snr_valid <= (i < 9);
            i_snr_estimate_db <= 10'(qe[i % 9]);
            i_snr_measurable <= (i < 8);
            if (i > 0) begin
                #1 chk(o_quality_report_code, qx[i - 1]);
                chk(o_quality_valid, 1'h1);
            end
            @(posedge i_clk);
        end
        wb(1'h1, OFF_CTRL, 32'h7, r);
        pkt(10'h8, 8'hB5);
        wb(1'h1, OFF_CTRL, 32'h4, r);
        pkt(10'h8, 8'h00);
        wb(1'h1, OFF_CTRL, 32'h5, r);
        $display("quality done");
        wb(1'h1, OFF_CEILING, 32'h40, r);
        en(16'h0000, 1'h1, 8'h00, 1'h1);
        en(16'h1234, 1'h0, 8'h12, 1'h0);
        en(16'hFF00, 1'h0, 8'h40, 1'h1);
        rd(OFF_LQ_STATUS, 32'h00014000);
        $display("strength done");
        @(posedge i_clk);
        i_tx_active <= 1'h1;
        rp(1'h1, 1'h1);
        ts = o_ranging_timestamp;
        @(posedge i_clk);
        {i_tx_active, i_rx_active} <= 2'h1;
        #1 chk(cal, ts + TXD);
        // 25 cycles between captures is a whole number of counts
        repeat (22) @(posedge i_clk);
        rp(1'h0, 1'h1);
        chk(((o_ranging_timestamp - ts) >> 3) & 32'h7FFF, 32'h42);
        ts = o_ranging_timestamp;
        @(posedge i_clk);
        #1 chk(cal, ts - RXD);
        rd(OFF_CAP_STAT, 32'h3);
        wb(1'h1, OFF_CAP_STAT, 32'h1, r);
        rd(OFF_CAP_STAT, 32'h2);
        wb(1'h1, OFF_CTRL, 32'h1, r);
        rp(1'h0, 1'h0);
        wb(1'h1, OFF_CTRL, 32'h5, r);
        repeat (12500) @(posedge i_clk);
        rp(1'h0, 1'h1);
        wb(1'h0, OFF_RANGE_TIME, 32'h0, r);
        chk(r & 32'hFFFC0007, 32'h0);
        rd(OFF_PKT_COUNT, 32'hB);
        $display("ranging done");
        conclude();
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        n_fail++;
        conclude();
    end
endmodule
`default_nettype wire
